// ===== core/module_off_control.sv
// Peripheral module disable registers and per-module clock/reset gating
`include "module_off_regs.svh"
`default_nettype none
module module_off_control #(
    parameter int NUM_REGS = 8,
    parameter int REG_W = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scan_allow_config,
    output logic [63:0] module_clk_en,
    output logic [63:0] module_reset_hold,
    output logic change_detect_off,
    output logic memory_scan_off,
    output logic nonvolatile_access_off,
    output logic nonvolatile_ready,
    output logic system_clock_network_off,
    output logic dma_channel_one_off,
    output logic dma_channel_two_off,
    output logic timer_one_off,
    output logic timer_three_off,
    output logic timer_five_off
);
    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    // The map and masks are fixed at eight byte-wide registers
    if (NUM_REGS != 8 || REG_W != 8) begin : g_bad_size
        $error("module_off_control supports only 8 registers of 8 bits");
    end

    localparam int SETTLE_RAW = `NVM_SETTLE_CYCLES;
    localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
    localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);

    // -------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // Async assert, sync release so no register leaves reset mid-edge
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // -------------------------------------------------------------------
    // Scan configuration input synchroniser
    // -------------------------------------------------------------------
    logic scan_meta_reg;
    logic scan_sync_reg;

    // Config bit arrives from another domain; two stages before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scan_meta_reg <= 1'b0;
            scan_sync_reg <= 1'b0;
        end else if (ce) begin
            scan_meta_reg <= scan_allow_config;
            scan_sync_reg <= scan_meta_reg;
        end
    end

    // -------------------------------------------------------------------
    // Disable register file
    // -------------------------------------------------------------------
    module_off_pkg::reg_req_t req;
    logic [7:0] mask [8];
    logic [7:0] off_reg [8];
    logic [7:0] off_next [8];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    assign mask[0] = `MOD_OFF_REG0_MASK;
    assign mask[1] = `MOD_OFF_REG1_MASK;
    assign mask[2] = `MOD_OFF_REG2_MASK;
    assign mask[3] = `MOD_OFF_REG3_MASK;
    assign mask[4] = `MOD_OFF_REG4_MASK;
    assign mask[5] = `MOD_OFF_REG5_MASK;
    assign mask[6] = `MOD_OFF_REG6_MASK;
    assign mask[7] = `MOD_OFF_REG7_MASK;

    // Write only touches implemented bits of the addressed register
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            off_next[i] = off_reg[i];
            if (req.wr && req.addr == 3'(i)) begin
                off_next[i] = req.wdata & mask[i];
            end
        end
        rdata_next = 8'h00;
        if (req.rd) begin
            rdata_next = off_reg[req.addr] & mask[req.addr];
        end
    end

    // Every register comes out of reset cleared, all modules running
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                off_reg[i] <= `MOD_OFF_RESET;
            end
            rdata_reg <= 8'h00;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                off_reg[i] <= off_next[i];
            end
            rdata_reg <= rdata_next;
        end
    end

    // Read data stands only in the cycle after the read strobe
    assign reg_rdata = rdata_reg;

    // -------------------------------------------------------------------
    // Effective disable vector, one bit per peripheral slot
    // -------------------------------------------------------------------
    logic [63:0] off_vec;

    // Scan disable is masked off unless configuration permits it
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            off_vec[i*8 +: 8] = off_reg[i] & mask[i];
        end
        off_vec[`MEMORY_SCAN_OFF_BIT] =
            off_reg[0][`MEMORY_SCAN_OFF_BIT] & scan_sync_reg;
    end

    // -------------------------------------------------------------------
    // Per-module gates
    // -------------------------------------------------------------------
    // Each slot has its own gate so bits never interact
    for (genvar g = 0; g < 64; g++) begin : g_gate
        module_off_pkg::gate_t gate;
        module_gate u_gate (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .ce(ce),
            .off(off_vec[g]),
            .gate(gate)
        );
        assign module_clk_en[g] = gate.clk_en;
        assign module_reset_hold[g] = gate.reset_hold;
    end

    // -------------------------------------------------------------------
    // Named function controls
    // -------------------------------------------------------------------
    assign change_detect_off = off_vec[`CHANGE_DETECT_OFF_BIT];
    assign memory_scan_off = off_vec[`MEMORY_SCAN_OFF_BIT];
    assign nonvolatile_access_off = off_vec[`NONVOLATILE_ACCESS_OFF_BIT];
    assign system_clock_network_off =
        off_vec[`SYSTEM_CLOCK_NETWORK_OFF_BIT];
    assign timer_one_off = off_vec[8 + `TIMER_ONE_OFF_BIT];
    assign timer_three_off = off_vec[8 + `TIMER_THREE_OFF_BIT];
    assign timer_five_off = off_vec[8 + `TIMER_FIVE_OFF_BIT];
    assign dma_channel_one_off =
        off_vec[56 + `DMA_CHANNEL_ONE_OFF_BIT];
    assign dma_channel_two_off =
        off_vec[56 + `DMA_CHANNEL_TWO_OFF_BIT];

    // -------------------------------------------------------------------
    // Nonvolatile settling indicator
    // -------------------------------------------------------------------
    logic [7:0] settle_reg;
    logic [7:0] settle_next;

    // Software is expected to wait; this shows when the wait is over
    always_comb begin
        settle_next = settle_reg;
        if (nonvolatile_access_off) begin
            settle_next = SETTLE_CNT;
        end else if (settle_reg != 8'h00) begin
            settle_next = settle_reg - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settle_reg <= 8'h00;
        end else if (ce) begin
            settle_reg <= settle_next;
        end
    end

    assign nonvolatile_ready =
        ~nonvolatile_access_off & (settle_reg == 8'h00);

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_gate_off;
        @(posedge clk_sys) disable iff (!rst_n)
        off_vec[12] |-> !module_clk_en[12] && module_reset_hold[12];
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("disabled module not gated");

    property p_change_detect;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && req.wr && req.addr == 3'h0 ##1 1'b1
            |-> change_detect_off == $past(req.wdata[0]);
    endproperty
    a_change_detect: assert property (p_change_detect)
        else $error("change detect off not following write");

    property p_scan_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        !scan_sync_reg |-> !memory_scan_off;
    endproperty
    a_scan_gate: assert property (p_scan_gate)
        else $error("scan disable acted without config");

    property p_dma_two;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && req.wr && req.addr == 3'h7
            |=> dma_channel_two_off == $past(req.wdata[1])
                && !module_clk_en[57] == dma_channel_two_off;
    endproperty
    a_dma_two: assert property (p_dma_two)
        else $error("dma two disable wrong");

    property p_dma_one;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && req.wr && req.addr == 3'h7
            |=> dma_channel_one_off == $past(req.wdata[0]);
    endproperty
    a_dma_one: assert property (p_dma_one)
        else $error("dma one disable wrong");

    property p_timers;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && req.wr && req.addr == 3'h1
            |=> {timer_five_off, timer_three_off, timer_one_off}
                == {$past(req.wdata[5]), $past(req.wdata[3]),
                    $past(req.wdata[1])};
    endproperty
    a_timers: assert property (p_timers)
        else $error("timer disable bits wrong");

    property p_unimpl_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && req.rd && req.addr == 3'h7 |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bits read nonzero");

    property p_power;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(off_vec[0]) |-> !module_clk_en[0] ##1 module_reset_hold[0];
    endproperty
    a_power: assert property (p_power)
        else $error("clock not removed on disable");

    property p_settle;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && $fell(nonvolatile_access_off) |-> !nonvolatile_ready;
    endproperty
    a_settle: assert property (p_settle)
        else $error("nonvolatile ready too early");

    property p_indep;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && req.wr && req.addr == 3'h3 |=> $stable(off_reg[4]);
    endproperty
    a_indep: assert property (p_indep)
        else $error("write disturbed another register");
endmodule
`default_nettype wire

// ===== core/module_off_regs.svh
// Register offsets, field positions, reset values and timing for module disable
`ifndef MODULE_OFF_REGS_SVH
`define MODULE_OFF_REGS_SVH

`define MOD_OFF_ADDR_W 3
`define MOD_OFF_REG0_ADDR 3'h0
`define MOD_OFF_REG1_ADDR 3'h1
`define MOD_OFF_REG2_ADDR 3'h2
`define MOD_OFF_REG3_ADDR 3'h3
`define MOD_OFF_REG4_ADDR 3'h4
`define MOD_OFF_REG5_ADDR 3'h5
`define MOD_OFF_REG6_ADDR 3'h6
`define MOD_OFF_REG7_ADDR 3'h7

// Writable masks; clear bits are unimplemented and read zero
`define MOD_OFF_REG0_MASK 8'hff
`define MOD_OFF_REG1_MASK 8'hff
`define MOD_OFF_REG2_MASK 8'h67
`define MOD_OFF_REG3_MASK 8'hff
`define MOD_OFF_REG4_MASK 8'he0
`define MOD_OFF_REG5_MASK 8'h37
`define MOD_OFF_REG6_MASK 8'h3f
`define MOD_OFF_REG7_MASK 8'h03
`define MOD_OFF_RESET 8'h00

// Field positions in register 0
`define CHANGE_DETECT_OFF_BIT 0
`define NONVOLATILE_ACCESS_OFF_BIT 2
`define MEMORY_SCAN_OFF_BIT 3
`define SYSTEM_CLOCK_NETWORK_OFF_BIT 7
// Field positions in register 1
`define TIMER_ONE_OFF_BIT 1
`define TIMER_THREE_OFF_BIT 3
`define TIMER_FIVE_OFF_BIT 5
// Field positions in register 7
`define DMA_CHANNEL_ONE_OFF_BIT 0
`define DMA_CHANNEL_TWO_OFF_BIT 1

// Settling time after the nonvolatile module is switched back on
`define NVM_SETTLE_NS 1000
`define CLK_SYS_PERIOD_NS 20
`define NVM_SETTLE_CYCLES (`NVM_SETTLE_NS / `CLK_SYS_PERIOD_NS)

`endif

// ===== core/module_off_pkg.sv
// Types shared by the module disable block
`default_nettype none
package module_off_pkg;
    // Register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Gating answer for one peripheral
    typedef struct packed {
        logic clk_en;
        logic reset_hold;
    } gate_t;
endpackage
`default_nettype wire

// ===== core/module_gate.sv
// Per-peripheral clock gate enable and reset hold derived from one disable bit
`default_nettype none
module module_gate (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic off,
    output var module_off_pkg::gate_t gate
);
    logic hold_reg;
    logic hold_next;

    // Reset is raised at once with the disable; released a cycle after clock
    // returns, so the peripheral sees one clean edge while still in reset
    always_comb begin
        hold_next = off;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 1'b0;
        end else if (ce) begin
            hold_reg <= hold_next;
        end
    end

    assign gate.clk_en = ~off;
    assign gate.reset_hold = off | hold_reg;
endmodule
`default_nettype wire

// ===== test/periph_model.sv
// Behavioural peripheral fed by one gated clock enable and reset hold
`default_nettype none
module periph_model (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic reset_hold,
    output logic [7:0] count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Activity counter
    // ------------------------------------------------------------
    // Held at zero in reset, frozen while its clock is cut off
    always_ff @(posedge clk_sys) begin
        if (reset_hold) begin
            count <= 8'h00;
        end else if (clk_en) begin
            count <= count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== test/module_off_control_tb.sv
// Self-checking bench for the module disable registers
`include "module_off_regs.svh"
`default_nettype none
module module_off_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, ce, reg_wr, reg_rd, scan_cfg;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val, t1_cnt, d2_cnt;
    logic [63:0] clk_en, rst_hold;
    logic cd, ms, nv, nrdy, sy, d1, d2, t1, t3, t5;
    // Named controls other than memory scan in one byte, change detect in the top bit
    wire logic [7:0] flags = {cd, nv, sy, t1, t3, t5, d1, d2};
    int fail_count = 0;
    int samples_checked = 0;
    logic [7:0] masks [8] = '{`MOD_OFF_REG0_MASK, `MOD_OFF_REG1_MASK,
        `MOD_OFF_REG2_MASK, `MOD_OFF_REG3_MASK, `MOD_OFF_REG4_MASK,
        `MOD_OFF_REG5_MASK, `MOD_OFF_REG6_MASK, `MOD_OFF_REG7_MASK};

    module_off_control dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_allow_config(scan_cfg),
        .module_clk_en(clk_en), .module_reset_hold(rst_hold),
        .change_detect_off(cd), .memory_scan_off(ms),
        .nonvolatile_access_off(nv), .nonvolatile_ready(nrdy),
        .system_clock_network_off(sy), .dma_channel_one_off(d1),
        .dma_channel_two_off(d2), .timer_one_off(t1),
        .timer_three_off(t3), .timer_five_off(t5));
    // Far-side peripherals on the timer one and DMA two slots
    periph_model tmr_one (.clk_sys(clk_sys), .clk_en(clk_en[9]),
        .reset_hold(rst_hold[9]), .count(t1_cnt));
    periph_model dma_two (.clk_sys(clk_sys), .clk_en(clk_en[57]),
        .reset_hold(rst_hold[57]), .count(d2_cnt));

    // ------------------------------------------------------------
    // Clock, checking and bus helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // One-cycle write; outputs are settled 1 ns after the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int r = 0; r < 8; r++) begin
            rd(3'(r));
            chk("reset rdata", 64'h0, {56'h0, rd_val});
        end
        chk("reset clk_en", '1, clk_en);
        chk("reset hold", 64'h0, rst_hold);
        chk("reset nvm ready", 64'h1, {63'h0, nrdy});
    endtask

    // All ones into every register: only the masked bits stick
    task automatic t_masks();
        logic [7:0] act;
        for (int r = 0; r < 8; r++) begin
            // Scan slot keeps running while its config bit is still clear
            act = masks[r];
            if (r == 0) begin
                act[`MEMORY_SCAN_OFF_BIT] = 1'b0;
            end
            wr(3'(r), 8'hff);
            chk("slot clk_en", {56'h0, ~act},
                {56'h0, clk_en[8*r+:8]});
            chk("slot hold", {56'h0, act},
                {56'h0, rst_hold[8*r+:8]});
            rd(3'(r));
            chk("masked rdata", {56'h0, masks[r]}, {56'h0, rd_val});
            wr(3'(r), 8'h00);
        end
    endtask

    // One named bit at a time must gate exactly its own slot
    task automatic t_fields();
        logic [2:0] ra [8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h7,
            3'h7};
        int bt [8] = '{0, 2, 7, 1, 3, 5, 0, 1};
        int s;
        for (int i = 0; i < 8; i++) begin
            s = 8 * ra[i] + bt[i];
            wr(ra[i], 8'h01 << bt[i]);
            chk("flags", {56'h0, 8'h80 >> i},
                {56'h0, flags});
            chk("one clk_en", ~(64'h1 << s), clk_en);
            chk("one hold", 64'h1 << s, rst_hold);
            wr(ra[i], 8'h00);
            chk("flags clear", 64'h0, {56'h0, flags});
        end
    endtask

    // Scan disable only acts while the configuration allows it
    task automatic t_scan();
        wr(3'h0, 8'h08);
        chk("scan gated", 64'h0, {63'h0, ms});
        rd(3'h0);
        chk("scan stored", 64'h8, {56'h0, rd_val});
        @(posedge clk_sys);
        scan_cfg <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("scan acts", 64'h1, {63'h0, ms});
        wr(3'h0, 8'h00);
        chk("scan off", 64'h0, {63'h0, ms});
    endtask

    // Nonvolatile access waits out its settling time before use
    task automatic t_nvm();
        int n;
        wr(3'h0, 8'h04);
        wr(3'h0, 8'h00);
        chk("nvm not ready", 64'h0, {63'h0, nrdy});
        repeat (40) @(posedge clk_sys);
        #1;
        chk("nvm settling", 64'h0, {63'h0, nrdy});
        n = 0;
        while (nrdy !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("nvm ready", 64'h1, {63'h0, nrdy});
        // Ready must come exactly when the settling count has run out
        chk("nvm wait", 64'(`NVM_SETTLE_CYCLES - 40),
            64'(n));
    endtask

    // Peripherals stay cleared while off; timer one runs again once released
    task automatic t_partner();
        wr(3'h1, 8'h02);
        wr(3'h7, 8'h02);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("timer held", 64'h0, {56'h0, t1_cnt});
        chk("dma idle", 64'h0, {56'h0, d2_cnt});
        wr(3'h1, 8'h00);
        chk("hold lingers", 64'h1, {63'h0, rst_hold[9]});
        repeat (6) @(posedge clk_sys);
        #1;
        chk("timer runs", 64'h5, {56'h0, t1_cnt});
        chk("dma still idle", 64'h0, {56'h0, d2_cnt});
        wr(3'h7, 8'h00);
    endtask

    // A write while the clock enable is low leaves the register alone
    task automatic t_freeze();
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(3'h3, 8'haa);
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(3'h3);
        chk("frozen reg", 64'h0, {56'h0, rd_val});
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        scan_cfg = 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_masks();
        t_fields();
        t_scan();
        t_nvm();
        t_partner();
        t_freeze();
        stop_test();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
